/* File: dv/pcg_chk.sv */
// Port checker of the clock gating block.
// Assumes one clock and a synchronous active-high reset.
`include "pcg_regs.vh"
module pcg_chk (
    input logic clk_i,
    input logic rst_i,
    input logic cyc_i,
    input logic stb_i,
    input logic we_i,
    input logic [`PCG_ADDR_W-1:0] adr_i,
    input logic [3:0] sel_i,
    input logic [31:0] dat_i,
    input logic [31:0] dat_o,
    input logic ack_o,
    input logic sleep_req_i,
    input logic deep_req_i,
    input logic periph_access_i,
    input logic [2:0] periph_sel_i,
    input logic periph_fault_o,
    input logic periph_ok_o,
    input logic [`PCG_NPERIPH-1:0] clk_en_o,
    input logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bad ack");
    reset_zero_a: assert property ($fell(rst_i) |-> clk_en_o == 0) else $error("enable after reset");
    gated_fault_a: assert property (periph_access_i && !clk_en_o[periph_sel_i] |=> periph_fault_o && !periph_ok_o)
        else $error("no fault");
    clocked_ok_a: assert property (periph_access_i && clk_en_o[periph_sel_i] |=> periph_ok_o && !periph_fault_o)
        else $error("no ok");
    wdog_fault_a: assert property (periph_access_i && periph_sel_i == 3'h7 && !clk_en_o[7] |=> periph_fault_o)
        else $error("watchdog no fault");
    idle_quiet_a: assert property (!periph_access_i |=> !periph_fault_o && !periph_ok_o) else $error("stray");
    run_rsvd_a: assert property (ack_o && !we_i && adr_i == `PCG_OFS_RUN |-> (dat_o & ~`PCG_GATE1_MASK) == 0)
        else $error("reserved set");
    wdog_write_a: assert property (cyc_i && stb_i && we_i && !ack_o && adr_i == `PCG_OFS_GATE0 && sel_i[0]
        |=> ##1 clk_en_o[7] == $past(dat_i[3], 2)) else $error("watchdog gate");
endmodule
bind pcg_top pcg_chk u_chk (.*);

/* File: dv/pcg_host.sv */
// Software model: classic Wishbone master with one transfer task.
// Assumes the slave gives a one-cycle ack.
module pcg_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rd_i,
    output logic cyc_o = 1'b0,
    output logic stb_o = 1'b0,
    output logic we_o = 1'b0,
    output logic [11:0] adr_o = 12'h000,
    output logic [3:0] sel_o = 4'hF,
    output logic [31:0] wd_o = 32'h00000000
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        wd_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rd_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released data must not keep looking valid
        wd_o <= ~d;
    endtask
endmodule

/* File: dv/peripheral_clock_gating_test.sv */
// Self-checking bench of the clock gating block.
// Assumes ack one cycle after a request and enables one edge after the ack.
`include "pcg_regs.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, g); end end
module peripheral_clock_gating_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc_i, stb_i, we_i, ack_o, periph_fault_o, periph_ok_o, irq_o;
    logic sleep_req_i = 0, deep_req_i = 0, periph_access_i = 0;
    logic [11:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q, v, s, p;
    logic [2:0] periph_sel_i = 0;
    logic [7:0] clk_en_o, pe = 0;
    int n_fail = 0, n_tests = 0, seed = 32'hb83c527a;
    pcg_top u_dut (.*);
    pcg_host u_host (.clk_i(clk_i), .ack_i(ack_o), .rd_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
        .adr_o(adr_i), .sel_o(sel_i), .wd_o(dat_i));
    function automatic logic [7:0] ens(logic [31:0] g, logic wd);
        return {wd, g[19:16], g[8], g[4], g[0]};
    endfunction
    task automatic settle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        u_host.xfer(0, a, 0, q);
        `CHK("read", e, q)
    endtask
    task automatic conclude();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        repeat (4000) @(posedge clk_i);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        rd(`PCG_OFS_RUN, 0);
        rd(`PCG_OFS_DEEP, 0);
        rd(`PCG_OFS_GATE0, 32'h40);
        rd(12'hFFC, 0);
        `CHK("reset enables", 8'h00, clk_en_o)
        u_host.xfer(1, `PCG_OFS_IRQ_EN, 32'h4, q);
        rd(`PCG_OFS_IRQ_EN, 32'h4);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            // First pass writes all ones so reserved bits are hit
            v = (i == 0) ? 32'hFFFFFFFF : $random(seed);
            u_host.xfer(1, `PCG_OFS_RUN, v, q);
            u_host.xfer(1, `PCG_OFS_GATE0, v, q);
            rd(`PCG_OFS_RUN, v & `PCG_GATE1_MASK);
            rd(`PCG_OFS_GATE0, (v & 32'h8) | 32'h40);
            `CHK("enables", ens(v, v[3]), clk_en_o)
            `CHK("irq", ens(v, v[3]) != pe, irq_o)
            pe = clk_en_o;
            for (int k = 0; k < 8; k++) begin
                @(posedge clk_i);
                periph_access_i <= 1;
                periph_sel_i <= 3'(k);
                settle(1);
                `CHK("fault", ~pe[k], periph_fault_o)
            end
            @(posedge clk_i);
            periph_access_i <= 0;
            u_host.xfer(1, `PCG_OFS_IRQ_CLR, 32'h7, q);
            settle(1);
            `CHK("irq clear", 1'b0, irq_o)
        end
        $display("run test done");
        s = ~v;
        p = $random(seed);
        u_host.xfer(1, `PCG_OFS_SLEEP, s, q);
        u_host.xfer(1, `PCG_OFS_DEEP, p, q);
        rd(`PCG_OFS_SLEEP, s & `PCG_GATE1_MASK);
        u_host.xfer(1, `PCG_OFS_CFG, 32'h1 << `PCG_BIT_ACG, q);
        sleep_req_i <= 1;
        settle(8);
        `CHK("sleep enables", ens(s, v[3]), clk_en_o)
        `CHK("sleep irq", 1'b1, irq_o)
        rd(`PCG_OFS_MODE, 32'h1);
        rd(`PCG_OFS_CFG, 32'h1 << `PCG_BIT_ACG);
        deep_req_i <= 1;
        settle(8);
        `CHK("deep enables", ens(p, v[3]), clk_en_o)
        rd(`PCG_OFS_MODE, 32'h2);
        rd(`PCG_OFS_IRQ_STAT, 32'h6);
        u_host.xfer(1, `PCG_OFS_CFG, 0, q);
        settle(2);
        `CHK("no auto gate", ens(v, v[3]), clk_en_o)
        $display("sleep test done");
        conclude();
    end
endmodule

/* File: logic/pcg_regs.vh */
// Register map, field positions and reset values of the peripheral clock gating block.
// Assumes a 32-bit classic Wishbone slave with byte addresses; offsets are byte addresses.
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

`define PCG_ADDR_W 12
`define PCG_OFS_GATE0 12'h100
`define PCG_OFS_RUN 12'h104
`define PCG_OFS_SLEEP 12'h114
`define PCG_OFS_DEEP 12'h124
`define PCG_OFS_CFG 12'h060
`define PCG_OFS_MODE 12'h140
`define PCG_OFS_IRQ_STAT 12'h150
`define PCG_OFS_IRQ_EN 12'h154
`define PCG_OFS_IRQ_CLR 12'h158

`define PCG_BIT_UART 0
`define PCG_BIT_SSI 4
`define PCG_BIT_QEI 8
`define PCG_BIT_TMR0 16
`define PCG_BIT_TMR1 17
`define PCG_BIT_TMR2 18
`define PCG_BIT_TMR3 19
`define PCG_BIT_WDOG 3
`define PCG_BIT_ACG 27

`define PCG_GATE1_MASK 32'h000F0111
`define PCG_GATE0_MASK 32'h00000008
`define PCG_GATE0_FIXED 32'h00000040
`define PCG_CFG_MASK 32'h08000000
`define PCG_RESET_VAL 32'h00000000

`define PCG_MODE_RUN 2'h0
`define PCG_MODE_SLEEP 2'h1
`define PCG_MODE_DEEP 2'h2

`define PCG_NPERIPH 8
`define PCG_IRQ_W 3
`define PCG_IRQ_FAULT 0
`define PCG_IRQ_MODE 1
`define PCG_IRQ_GATE 2

`endif

/* File: logic/pcg_sync.v */
// Two-flop synchroniser for a vector of asynchronous level inputs.
// Assumes the inputs are quasi-static levels; no bus of words crosses here.
module pcg_sync #(
    parameter W = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] meta_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else begin
            meta_ff <= async_i;
            sync_o <= meta_ff;
        end
    end
endmodule

/* File: logic/pcg_top.v */
// Peripheral clock gating control: run, sleep and deep-sleep gate registers, watchdog gate,
// auto-gate select, per-peripheral clock enables and a bus-fault verdict for peripheral accesses.
// Assumes one 40 MHz clock, synchronous active-high reset, classic Wishbone from software,
// and power mode request pins from outside the clock domain.
// Contract
// - Set gate bit clocks its peripheral
// - Access to gated peripheral gets bus fault
// - Watchdog enable is bit 3, resets zero
// - Watchdog gated means watchdog accesses fault
// - All gate bits reset to zero
// - Run gate register at 0x104, reset zero
// - Separate sleep and deep-sleep gate sets
// - Sleep sets apply only with auto-gate flag
// - Bit 8 gates quadrature encoder zero
// - Bit 4 gates synchronous serial zero
// - Bit 0 gates asynchronous serial zero
// - Bit 16 gates timer zero
// - Bits 17-19 gate timers one to three
// - Reserved bits read-only; software preserves them
// - Sleep at 0x114, deep sleep at 0x124
`include "pcg_regs.vh"
module pcg_top (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`PCG_ADDR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire sleep_req_i,
    input wire deep_req_i,
    input wire periph_access_i,
    input wire [2:0] periph_sel_i,
    output reg periph_fault_o,
    output reg periph_ok_o,
    output reg [`PCG_NPERIPH-1:0] clk_en_o,
    output reg irq_o
);
    // Peripheral select codes on periph_sel_i
    localparam [2:0] P_UART = 3'h0;
    localparam [2:0] P_SSI = 3'h1;
    localparam [2:0] P_QEI = 3'h2;
    localparam [2:0] P_TMR0 = 3'h3;
    localparam [2:0] P_TMR1 = 3'h4;
    localparam [2:0] P_TMR2 = 3'h5;
    localparam [2:0] P_TMR3 = 3'h6;
    localparam [2:0] P_WDOG = 3'h7;

    reg [31:0] run_gate_reg_ff;
    reg [31:0] sleep_gate_reg_ff;
    reg [31:0] deep_sleep_gate_reg_ff;
    reg watchdog_gate_ff;
    reg auto_gate_select_ff;
    reg [1:0] mode_ff;
    reg [1:0] nxt_mode;
    reg [`PCG_IRQ_W-1:0] irq_stat_ff;
    reg [`PCG_IRQ_W-1:0] irq_en_ff;
    reg [`PCG_IRQ_W-1:0] irq_set;
    reg [`PCG_IRQ_W-1:0] irq_clr;
    reg [31:0] eff_gate;
    reg eff_wdog;
    reg [`PCG_NPERIPH-1:0] nxt_clk_en;
    reg [31:0] nxt_rdata;
    wire [31:0] wmask;
    reg req_ok;
    wire [1:0] req_sync;
    wire bus_req;
    wire bus_wr;

    pcg_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({deep_req_i, sleep_req_i}),
        .sync_o(req_sync)
    );

    // Byte-lane merge of write data over a stored word, limited to writable bits
    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        input [31:0] rw_mask;
        reg [31:0] bytes;
        begin
            bytes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
            lane_merge = (old_v & ~(bytes & rw_mask)) | (new_v & bytes & rw_mask);
        end
    endfunction

    // Map the 32-bit gate word to the packed enable vector
    function [`PCG_NPERIPH-1:0] gate_vec;
        input [31:0] g;
        input wd;
        begin
            gate_vec = {wd, g[`PCG_BIT_TMR3], g[`PCG_BIT_TMR2], g[`PCG_BIT_TMR1], g[`PCG_BIT_TMR0],
                        g[`PCG_BIT_QEI], g[`PCG_BIT_SSI], g[`PCG_BIT_UART]};
        end
    endfunction

    // Only documented enable bits take writes; reserved positions keep their value
    assign wmask = `PCG_GATE1_MASK;
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr = bus_req & we_i;

    // Deep sleep request takes priority over plain sleep
    always @* begin
        nxt_mode = `PCG_MODE_RUN;
        if (req_sync[1]) begin
            nxt_mode = `PCG_MODE_DEEP;
        end else if (req_sync[0]) begin
            nxt_mode = `PCG_MODE_SLEEP;
        end
    end

    // Sleep sets take over only with auto gating; otherwise run settings stay in force
    always @* begin
        eff_gate = run_gate_reg_ff;
        if (auto_gate_select_ff && mode_ff == `PCG_MODE_SLEEP) begin
            eff_gate = sleep_gate_reg_ff;
        end else if (auto_gate_select_ff && mode_ff == `PCG_MODE_DEEP) begin
            eff_gate = deep_sleep_gate_reg_ff;
        end
        eff_wdog = watchdog_gate_ff;
        nxt_clk_en = gate_vec(eff_gate, eff_wdog);
    end

    always @* begin
        case (periph_sel_i)
            P_UART: req_ok = clk_en_o[0];
            P_SSI: req_ok = clk_en_o[1];
            P_QEI: req_ok = clk_en_o[2];
            P_TMR0: req_ok = clk_en_o[3];
            P_TMR1: req_ok = clk_en_o[4];
            P_TMR2: req_ok = clk_en_o[5];
            P_TMR3: req_ok = clk_en_o[6];
            P_WDOG: req_ok = clk_en_o[7];
            default: req_ok = 1'b0;
        endcase
    end

    always @* begin
        nxt_rdata = 32'h00000000;
        case (adr_i)
            `PCG_OFS_GATE0: nxt_rdata = `PCG_GATE0_FIXED | ({31'h00000000, watchdog_gate_ff} << `PCG_BIT_WDOG);
            `PCG_OFS_RUN: nxt_rdata = run_gate_reg_ff;
            `PCG_OFS_SLEEP: nxt_rdata = sleep_gate_reg_ff;
            `PCG_OFS_DEEP: nxt_rdata = deep_sleep_gate_reg_ff;
            `PCG_OFS_CFG: nxt_rdata = {31'h00000000, auto_gate_select_ff} << `PCG_BIT_ACG;
            `PCG_OFS_MODE: nxt_rdata = {30'h00000000, mode_ff};
            `PCG_OFS_IRQ_STAT: nxt_rdata = {29'h00000000, irq_stat_ff};
            `PCG_OFS_IRQ_EN: nxt_rdata = {29'h00000000, irq_en_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // Events: peripheral fault, power mode change, effective gate change
    always @* begin
        irq_set = {`PCG_IRQ_W{1'b0}};
        irq_set[`PCG_IRQ_FAULT] = periph_access_i & ~req_ok;
        irq_set[`PCG_IRQ_MODE] = (nxt_mode != mode_ff);
        irq_set[`PCG_IRQ_GATE] = (nxt_clk_en != clk_en_o);
        irq_clr = {`PCG_IRQ_W{1'b0}};
        if (bus_wr && adr_i == `PCG_OFS_IRQ_CLR && sel_i[0]) begin
            irq_clr = dat_i[`PCG_IRQ_W-1:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            run_gate_reg_ff <= `PCG_RESET_VAL;
            sleep_gate_reg_ff <= `PCG_RESET_VAL;
            deep_sleep_gate_reg_ff <= `PCG_RESET_VAL;
            watchdog_gate_ff <= 1'b0;
            auto_gate_select_ff <= 1'b0;
        end else if (bus_wr) begin
            case (adr_i)
                `PCG_OFS_RUN: run_gate_reg_ff <= lane_merge(run_gate_reg_ff, dat_i, sel_i, wmask);
                `PCG_OFS_SLEEP: sleep_gate_reg_ff <= lane_merge(sleep_gate_reg_ff, dat_i, sel_i, wmask);
                `PCG_OFS_DEEP: deep_sleep_gate_reg_ff <= lane_merge(deep_sleep_gate_reg_ff, dat_i, sel_i, wmask);
                `PCG_OFS_GATE0: begin
                    if (sel_i[0]) begin
                        watchdog_gate_ff <= dat_i[`PCG_BIT_WDOG];
                    end
                end
                `PCG_OFS_CFG: begin
                    if (sel_i[3]) begin
                        auto_gate_select_ff <= dat_i[`PCG_BIT_ACG];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= `PCG_MODE_RUN;
            clk_en_o <= {`PCG_NPERIPH{1'b0}};
            periph_fault_o <= 1'b0;
            periph_ok_o <= 1'b0;
            irq_stat_ff <= {`PCG_IRQ_W{1'b0}};
            irq_en_ff <= {`PCG_IRQ_W{1'b0}};
            irq_o <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            mode_ff <= nxt_mode;
            clk_en_o <= nxt_clk_en;
            periph_fault_o <= periph_access_i & ~req_ok;
            periph_ok_o <= periph_access_i & req_ok;
            // Set wins over a clear in the same cycle
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            if (bus_wr && adr_i == `PCG_OFS_IRQ_EN && sel_i[0]) begin
                irq_en_ff <= dat_i[`PCG_IRQ_W-1:0];
            end
            irq_o <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
            ack_o <= bus_req;
            dat_o <= (bus_req && !we_i) ? nxt_rdata : 32'h00000000;
        end
    end
endmodule
